// File: rif_pkg.sv
// Package of start-up values, field positions and types for the reset forcer
package rif_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int FETCH_CYCLES = 3;
  localparam logic [1:0] FETCH_LAST = 2'h2;
  localparam int PIN_DRIVE_CYCLES = 4;
  localparam int EXP_PINS = 18;
  localparam int N_COMPARE = 5;
  localparam logic [15:0] VEC_NORMAL = 16'hfffe;
  localparam logic [15:0] VEC_SPECIAL = 16'hbffe;
  localparam int RAM_BYTES = 256;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam logic [15:0] REG_BASE = 16'h1000;
  localparam logic [15:0] REG_END = 16'h103f;
  localparam logic [7:0] RAM_MAP_RST = 8'h01;
  localparam logic [7:0] CCR_RST = 8'hd0;
  localparam int CCR_S = 7;
  localparam int CCR_X = 6;
  localparam int CCR_I = 4;
  localparam int PARALLEL_IO_CONTROL_REG_STROBE_A_FLAG = 7;
  localparam int PARALLEL_IO_CONTROL_REG_STROBE_A_INT_ENABLE = 6;
  localparam int PARALLEL_IO_CONTROL_REG_PORT_C_OPEN_DRAIN_SELECT = 5;
  localparam int PARALLEL_IO_CONTROL_REG_HANDSHAKE_SELECT = 4;
  localparam int PARALLEL_IO_CONTROL_REG_EGA = 1;
  localparam logic [7:0] PARALLEL_IO_CONTROL_REG_RST = 8'h02;
  localparam logic [7:0] PORT_C_DIR_RST = 8'h00;
  localparam logic [7:0] PORT_B_SINGLE = 8'h00;
  localparam logic [7:0] PORT_B_EXP = 8'hff;
  localparam logic [7:0] PORT_A_DIR_RST = 8'h78;
  localparam logic [7:0] PORT_A_OUT_RST = 8'h00;
  localparam logic [5:0] PORT_D_DIR_RST = 6'h00;
  localparam logic [7:0] PORT_E_DIR_RST = 8'h00;
  localparam logic [15:0] TCNT_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'hffff;
  localparam logic [1:0] PRESCALE_RST = 2'h0;
  localparam logic [1:0] RTI_RATE_RST = 2'h0;
  localparam logic [1:0] WD_RATE_RST = 2'h0;
  localparam logic [3:0] PSEL_RST = 4'h5;
  localparam int HP_BOOT_ROM_READ_ENABLE = 7;
  localparam int HP_SPECIAL_MODE_BIT = 6;
  localparam int HP_MDA = 5;
  localparam int MODE_B_IDX = 1;
  localparam int MODE_A_IDX = 0;

  typedef enum logic [1:0] {ST_HOLD, ST_FETCH, ST_RUN} rif_state_t;

  typedef struct packed {
    logic power_on;
    logic clock_fail;
    logic watchdog_timeout;
  } rif_src_t;

  typedef struct packed {
    logic [7:0] condition_code_reg;
    logic [7:0] ram_map;
    logic [EXP_PINS-1:0] expansion_pins;
    logic [7:0] parallel_io_control_reg;
    logic [7:0] port_c_direction_reg;
    logic [7:0] port_b_out;
    logic [7:0] port_a_dir;
    logic [7:0] port_a_out;
    logic [5:0] port_d_dir;
    logic [7:0] port_e_dir;
    logic [15:0] timer_count;
    logic [1:0] prescale;
    logic [N_COMPARE-1:0][15:0] compare_regs;
    logic [7:0] compare1_pin_mask;
    logic [7:0] compare_pin_ctrl;
    logic [5:0] capture_edge;
    logic [8:0] timer_flags;
    logic [8:0] timer_masks;
    logic rti_flag;
    logic rti_mask;
    logic [1:0] rti_rate;
    logic pulse_acc_enable;
    logic spi_enable;
    logic wd_enable;
    logic [1:0] wd_rate;
    logic [3:0] sci_int_masks;
    logic sci_tx_enable;
    logic sci_rx_enable;
    logic sci_nine_bit;
    logic sci_break;
    logic sci_wakeup;
    logic tx_register_empty;
    logic tx_complete;
    logic rx_register_full;
    logic rx_idle;
    logic rx_overrun;
    logic rx_framing_error;
    logic converter_complete;
    logic converter_power_up;
    logic [7:0] eeprom_prog_ctrl;
    logic [7:0] priority_and_mode_reg;
    logic irq_edge;
    logic stop_recovery_delay;
    logic clock_monitor_enable;
  } rif_init_t;
endpackage : rif_pkg

// File: rif_mode_capture.sv
// Mode pin synchroniser and capture register, frozen when reset ends
`timescale 1ns/1ps
module rif_mode_capture #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pins_in,
  input wire logic hold,
  output logic [WIDTH-1:0] captured
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] cap_q;

  // Keeps following the pins while held, so the last level before release sticks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      cap_q <= '0;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      if (hold) begin
        cap_q <= sync_q;
      end
    end
  end

  assign captured = cap_q;
endmodule : rif_mode_capture

// File: rif_top.sv
// Reset start-up value forcer: gathers reset causes and drives start-up values
`timescale 1ns/1ps
module rif_top #(
  parameter int DRIVE_CYCLES = rif_pkg::PIN_DRIVE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_pin_n_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire rif_pkg::rif_src_t int_src,
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  input wire logic rom_enable_nv,
  input wire logic eeprom_enable_nv,
  input wire logic watchdog_disable_bit,
  output logic rom_enable,
  output logic eeprom_enable,
  output logic force_active,
  output rif_pkg::rif_init_t init_values,
  output logic [15:0] vector_addr,
  output logic [1:0] fetch_index,
  output logic vector_fetch,
  output logic cpu_run
);
  import rif_pkg::*;

  localparam int DW = $clog2(DRIVE_CYCLES + 1);

  logic pin_meta_q;
  logic pin_sync_q;
  logic [DW-1:0] drive_cnt_q;
  logic [DW-1:0] drive_cnt_d;
  logic internal_req;
  logic driving;
  logic sys_reset_w;
  logic [1:0] mode_cap;
  logic boot_w;
  logic special_w;
  logic mode_a_w;
  logic [15:0] vec_base_w;
  logic [7:0] priority_and_mode_reg_w;
  rif_init_t init_q;
  rif_init_t init_d;
  rif_state_t state_q;
  rif_state_t state_d;
  logic [1:0] fetch_cnt_q;
  logic [1:0] fetch_cnt_d;
  logic [15:0] vector_addr_q;

  // External reset pin crosses two flops; low while held in reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= reset_pin_n_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Internal causes stretch the pin drive so the outside system sees it
  assign internal_req = int_src.power_on | int_src.clock_fail | int_src.watchdog_timeout;
  assign driving = internal_req | (drive_cnt_q != '0);
  assign reset_pin_oe = driving;
  assign reset_pin_out = 1'b0;
  assign sys_reset_w = ~pin_sync_q | driving;
  assign force_active = sys_reset_w;

  assign drive_cnt_d = internal_req ? DW'(DRIVE_CYCLES) :
                       (drive_cnt_q != '0) ? drive_cnt_q - 1'b1 : drive_cnt_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drive_cnt_q <= '0;
    end else begin
      drive_cnt_q <= drive_cnt_d;
    end
  end

  rif_mode_capture #(
    .WIDTH(2)
  ) u_mode (
    .clock(clock),
    .rst(rst),
    .pins_in({mode_pin_b, mode_pin_a}),
    .hold(sys_reset_w),
    .captured(mode_cap)
  );

  // Mode decode from the captured pin levels
  assign boot_w = ~mode_cap[MODE_B_IDX] & ~mode_cap[MODE_A_IDX];
  assign special_w = ~mode_cap[MODE_B_IDX];
  assign mode_a_w = mode_cap[MODE_A_IDX];
  assign vec_base_w = special_w ? VEC_SPECIAL : VEC_NORMAL;

  always_comb begin
    priority_and_mode_reg_w = {4'h0, PSEL_RST};
    priority_and_mode_reg_w[HP_BOOT_ROM_READ_ENABLE] = boot_w;
    priority_and_mode_reg_w[HP_SPECIAL_MODE_BIT] = special_w;
    priority_and_mode_reg_w[HP_MDA] = mode_a_w;
  end

  // Start-up values; fields not named stay zero
  always_comb begin
    init_d = '0;
    init_d.condition_code_reg = CCR_RST;
    init_d.ram_map = RAM_MAP_RST;
    init_d.expansion_pins = {EXP_PINS{mode_a_w}};
    init_d.parallel_io_control_reg = PARALLEL_IO_CONTROL_REG_RST;
    init_d.port_c_direction_reg = PORT_C_DIR_RST;
    init_d.port_b_out = mode_a_w ? PORT_B_EXP : PORT_B_SINGLE;
    init_d.port_a_dir = PORT_A_DIR_RST;
    init_d.port_a_out = PORT_A_OUT_RST;
    init_d.port_d_dir = PORT_D_DIR_RST;
    init_d.port_e_dir = PORT_E_DIR_RST;
    init_d.timer_count = TCNT_RST;
    init_d.prescale = PRESCALE_RST;
    init_d.compare_regs = {N_COMPARE{COMPARE_RST}};
    init_d.compare1_pin_mask = 8'h00;
    init_d.compare_pin_ctrl = 8'h00;
    init_d.capture_edge = 6'h00;
    init_d.timer_flags = 9'h000;
    init_d.timer_masks = 9'h000;
    init_d.rti_flag = 1'b0;
    init_d.rti_mask = 1'b0;
    init_d.rti_rate = RTI_RATE_RST;
    init_d.pulse_acc_enable = 1'b0;
    init_d.spi_enable = 1'b0;
    init_d.wd_enable = ~watchdog_disable_bit;
    init_d.wd_rate = WD_RATE_RST;
    init_d.sci_int_masks = 4'h0;
    init_d.sci_tx_enable = 1'b0;
    init_d.sci_rx_enable = 1'b0;
    init_d.sci_nine_bit = 1'b0;
    init_d.sci_break = 1'b0;
    init_d.sci_wakeup = 1'b0;
    init_d.tx_register_empty = 1'b1;
    init_d.tx_complete = 1'b1;
    init_d.rx_register_full = 1'b0;
    init_d.rx_idle = 1'b0;
    init_d.rx_overrun = 1'b0;
    init_d.rx_framing_error = 1'b0;
    init_d.converter_complete = 1'b0;
    init_d.converter_power_up = 1'b0;
    init_d.eeprom_prog_ctrl = 8'h00;
    init_d.priority_and_mode_reg = priority_and_mode_reg_w;
    init_d.irq_edge = 1'b0;
    init_d.stop_recovery_delay = 1'b1;
    init_d.clock_monitor_enable = 1'b0;
  end

  // Reloaded every cycle of reset, left alone once it ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_q <= '0;
    end else if (sys_reset_w) begin
      init_q <= init_d;
    end
  end

  assign init_values = init_q;

  // Nonvolatile enables bypass reset entirely
  assign rom_enable = rom_enable_nv;
  assign eeprom_enable = eeprom_enable_nv;

  // Release sequence: hold, three vector fetch cycles, then run
  always_comb begin
    state_d = state_q;
    fetch_cnt_d = 2'h0;
    case (state_q)
      ST_HOLD: begin
        state_d = ST_FETCH;
      end
      ST_FETCH: begin
        fetch_cnt_d = fetch_cnt_q + 2'h1;
        if (fetch_cnt_q == FETCH_LAST) begin
          state_d = ST_RUN;
          fetch_cnt_d = 2'h0;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
    if (sys_reset_w) begin
      state_d = ST_HOLD;
      fetch_cnt_d = 2'h0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_HOLD;
      fetch_cnt_q <= 2'h0;
      vector_addr_q <= VEC_NORMAL;
    end else begin
      state_q <= state_d;
      fetch_cnt_q <= fetch_cnt_d;
      vector_addr_q <= vec_base_w;
    end
  end

  assign vector_addr = vector_addr_q;
  assign fetch_index = fetch_cnt_q;
  assign vector_fetch = (state_q == ST_FETCH);
  assign cpu_run = (state_q == ST_RUN);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_release;
    (state_q == ST_HOLD) && !sys_reset_w;
  endsequence

  sequence s_quiet4;
    !sys_reset_w [*4];
  endsequence

  property p_fetch;
    s_release ##1 s_quiet4 |->
      cpu_run && $past(vector_fetch, 1) && $past(vector_fetch, 2) && $past(vector_fetch, 3);
  endproperty
  a_fetch: assert property (p_fetch) else $error("vector fetch not three cycles");

  property p_vector;
    vector_fetch |->
      vector_addr == (init_values.priority_and_mode_reg[HP_SPECIAL_MODE_BIT] ? VEC_SPECIAL : VEC_NORMAL);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong restart vector");

  property p_ccr;
    sys_reset_w |=> init_values.condition_code_reg[CCR_I] &&
      init_values.condition_code_reg[CCR_X] && init_values.condition_code_reg[CCR_S];
  endproperty
  a_ccr: assert property (p_ccr) else $error("interrupt masks not set");

  property p_map;
    sys_reset_w |=> init_values.ram_map == RAM_MAP_RST && init_values.port_c_direction_reg == '0;
  endproperty
  a_map: assert property (p_map) else $error("map or port C direction wrong");

  property p_expand;
    sys_reset_w |=> init_values.expansion_pins == {EXP_PINS{init_values.priority_and_mode_reg[HP_MDA]}};
  endproperty
  a_expand: assert property (p_expand) else $error("expansion pins mismatch");

  property p_watchdog;
    sys_reset_w |=> init_values.wd_enable == !$past(watchdog_disable_bit);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog enable wrong");

  property p_serial;
    sys_reset_w |=> init_values.tx_register_empty && init_values.tx_complete &&
      !init_values.rx_register_full && !init_values.rx_framing_error;
  endproperty
  a_serial: assert property (p_serial) else $error("serial status wrong");

  property p_mode_frozen;
    !sys_reset_w && $past(!sys_reset_w) |-> $stable(mode_cap);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode moved after reset");

  property p_pin_drive;
    internal_req |=> reset_pin_oe [*4];
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("reset pin drive too short");

  property p_pin_in;
    $fell(reset_pin_n_in) ##1 !reset_pin_n_in |=> force_active;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("pin reset not seen");

  property p_hold;
    !sys_reset_w |=> $stable(init_values);
  endproperty
  a_hold: assert property (p_hold) else $error("values changed outside reset");

  property p_timer;
    sys_reset_w |=> init_values.timer_flags == '0 && init_values.timer_masks == '0 &&
      init_values.compare_regs == {N_COMPARE{COMPARE_RST}} && init_values.timer_count == '0;
  endproperty
  a_timer: assert property (p_timer) else $error("timer start-up wrong");

  property p_parallel_io_control_reg;
    sys_reset_w |=> init_values.parallel_io_control_reg[PARALLEL_IO_CONTROL_REG_EGA] &&
      !init_values.parallel_io_control_reg[PARALLEL_IO_CONTROL_REG_STROBE_A_FLAG] &&
      !init_values.parallel_io_control_reg[PARALLEL_IO_CONTROL_REG_STROBE_A_INT_ENABLE] &&
      !init_values.parallel_io_control_reg[PARALLEL_IO_CONTROL_REG_HANDSHAKE_SELECT] &&
      !init_values.parallel_io_control_reg[PARALLEL_IO_CONTROL_REG_PORT_C_OPEN_DRAIN_SELECT];
  endproperty
  a_parallel_io_control_reg: assert property (p_parallel_io_control_reg) else $error("parallel control start-up wrong");

  property p_ports;
    sys_reset_w |=> init_values.port_a_dir == PORT_A_DIR_RST &&
      init_values.port_a_out == PORT_A_OUT_RST && init_values.port_d_dir == PORT_D_DIR_RST &&
      init_values.port_e_dir == PORT_E_DIR_RST;
  endproperty
  a_ports: assert property (p_ports) else $error("port directions wrong");

  property p_timer_pins;
    sys_reset_w |=> init_values.compare1_pin_mask == '0 &&
      init_values.compare_pin_ctrl == '0 && init_values.capture_edge == '0 &&
      init_values.prescale == PRESCALE_RST;
  endproperty
  a_timer_pins: assert property (p_timer_pins) else $error("compare or capture wrong");

  property p_rti;
    sys_reset_w |=> !init_values.rti_flag && !init_values.rti_mask &&
      init_values.rti_rate == RTI_RATE_RST && !init_values.pulse_acc_enable &&
      !init_values.spi_enable && init_values.wd_rate == WD_RATE_RST;
  endproperty
  a_rti: assert property (p_rti) else $error("periodic or pulse start-up wrong");

  property p_sci_ctrl;
    sys_reset_w |=> init_values.sci_int_masks == '0 && !init_values.sci_tx_enable &&
      !init_values.sci_rx_enable && !init_values.sci_nine_bit && !init_values.sci_break &&
      !init_values.sci_wakeup && !init_values.rx_idle && !init_values.rx_overrun;
  endproperty
  a_sci_ctrl: assert property (p_sci_ctrl) else $error("serial control wrong");

  property p_sysctl;
    sys_reset_w |=> !init_values.converter_complete && !init_values.converter_power_up &&
      init_values.eeprom_prog_ctrl == '0 && !init_values.irq_edge &&
      init_values.priority_and_mode_reg[3:0] == PSEL_RST &&
      init_values.stop_recovery_delay && !init_values.clock_monitor_enable;
  endproperty
  a_sysctl: assert property (p_sysctl) else $error("system controls wrong");
endmodule : rif_top

// File: rif_pin_model.sv
// Reset pin wire: pull-up, external pull-down and the open-drain device driver
`timescale 1ns/1ps
module rif_pin_model (
  input wire logic ext_pull_low,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic pin_n
);
  // Released line floats up through the pull-up, never holds a stale low
  assign pin_n = (ext_pull_low || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
endmodule : rif_pin_model

// File: rif_top_test.sv
// Self-checking bench for the reset start-up value forcer
`timescale 1ns/1ps
module rif_top_test;
  import rif_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ext_pull_low = 1'b1;
  logic mode_pin_a = 1'b0;
  logic mode_pin_b = 1'b1;
  logic rom_nv = 1'b1;
  logic eep_nv = 1'b0;
  logic wd_dis = 1'b0;
  rif_src_t int_src = '0;
  logic pin_n, pin_out, pin_oe, rom_en, eep_en, force_active, vector_fetch, cpu_run;
  rif_init_t iv;
  logic [15:0] vector_addr;
  logic [1:0] fetch_index;
  logic b, a;
  int bad_count = 0;
  int check_count = 0;
  int n;

  always #12.5 clock = ~clock;

  rif_top #(.DRIVE_CYCLES(4)) DUT (
    .clock(clock), .rst(rst), .reset_pin_n_in(pin_n), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .int_src(int_src), .mode_pin_a(mode_pin_a),
    .mode_pin_b(mode_pin_b), .rom_enable_nv(rom_nv), .eeprom_enable_nv(eep_nv),
    .watchdog_disable_bit(wd_dis), .rom_enable(rom_en), .eeprom_enable(eep_en),
    .force_active(force_active), .init_values(iv), .vector_addr(vector_addr),
    .fetch_index(fetch_index), .vector_fetch(vector_fetch), .cpu_run(cpu_run)
  );

  rif_pin_model PIN (
    .ext_pull_low(ext_pull_low), .dev_out(pin_out), .dev_oe(pin_oe), .pin_n(pin_n)
  );

  task check(input logic [511:0] seen, input logic [511:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Inputs always move the same small delay after the rising edge
  task step(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask : step

  task wait_force(input logic lvl);
    n = 0;
    while (force_active !== lvl && n < 100) begin
      step(1);
      n++;
    end
    check(force_active, lvl);
  endtask : wait_force

  task check_init(input logic mb, input logic ma, input logic wd);
    check(iv.condition_code_reg, 8'hd0);
    check(iv.ram_map, 8'h01);
    check(iv.expansion_pins, {18{ma}});
    check(iv.parallel_io_control_reg, 8'h02);
    check({iv.port_c_direction_reg, iv.port_b_out}, {8'h00, ma ? 8'hff : 8'h00});
    check({iv.port_a_dir, iv.port_a_out, iv.port_d_dir, iv.port_e_dir},
          {8'h78, 8'h00, 6'h00, 8'h00});
    check({iv.timer_count, iv.prescale, iv.compare_regs}, {16'h0000, 2'h0, {5{16'hffff}}});
    check({iv.compare1_pin_mask, iv.compare_pin_ctrl, iv.capture_edge}, 22'h000000);
    check({iv.timer_flags, iv.timer_masks}, 18'h00000);
    check({iv.rti_flag, iv.rti_mask, iv.rti_rate}, 4'h0);
    check({iv.pulse_acc_enable, iv.spi_enable}, 2'h0);
    check({iv.wd_enable, iv.wd_rate}, {~wd, 2'h0});
    check({iv.sci_int_masks, iv.sci_tx_enable, iv.sci_rx_enable, iv.sci_nine_bit,
           iv.sci_break, iv.sci_wakeup}, 9'h000);
    check({iv.tx_register_empty, iv.tx_complete, iv.rx_register_full, iv.rx_idle,
           iv.rx_overrun, iv.rx_framing_error}, 6'h30);
    check({iv.converter_complete, iv.converter_power_up}, 2'h0);
    check({iv.eeprom_prog_ctrl, iv.irq_edge}, 9'h000);
    check(iv.priority_and_mode_reg, {~mb & ~ma, ~mb, ma, 1'b0, 4'h5});
    check({iv.stop_recovery_delay, iv.clock_monitor_enable}, 2'h2);
    check({rom_en, eep_en}, {rom_nv, eep_nv});
  endtask : check_init

  // Release, then three fetch cycles on the selected pair, then run
  task release_and_fetch(input logic [15:0] vec);
    wait_force(1'b0);
    for (int i = 0; i < 3; i++) begin
      step(1);
      check({vector_fetch, fetch_index, vector_addr}, {1'b1, 2'(i), vec});
    end
    step(1);
    check({vector_fetch, cpu_run}, 2'h1);
  endtask : release_and_fetch

  initial begin
    step(6);
    rst = 1'b0;
    // Mode bits lag the pin sync by a capture edge and a load edge
    step(5);
    check({force_active, cpu_run}, 2'h2);
    check_init(1'b1, 1'b0, 1'b0);
    // All four mode pin settings, nonvolatile cells varied alongside
    for (int m = 0; m < 4; m++) begin
      {b, a} = 2'(m);
      mode_pin_b = b;
      mode_pin_a = a;
      wd_dis = a;
      rom_nv = b;
      eep_nv = ~a;
      ext_pull_low = 1'b1;
      step(5);
      check({force_active, cpu_run}, 2'h2);
      check_init(b, a, a);
      ext_pull_low = 1'b0;
      release_and_fetch(b ? 16'hfffe : 16'hbffe);
      // Late pin changes must not reach the captured mode bits
      mode_pin_b = ~b;
      mode_pin_a = ~a;
      step(6);
      check_init(b, a, a);
    end
    mode_pin_b = 1'b1;
    mode_pin_a = 1'b0;
    // Each internal cause pulls the pin and restarts the device
    for (int k = 0; k < 3; k++) begin
      int_src = rif_src_t'(3'h4 >> k);
      #1;
      check({pin_oe, pin_out, force_active}, 3'h5);
      step(1);
      int_src = '0;
      n = 0;
      while (pin_oe === 1'b1 && n < 50) begin
        step(1);
        n++;
      end
      check(n, 4);
      check(cpu_run, 1'b0);
      release_and_fetch(16'hfffe);
      check_init(1'b1, 1'b0, wd_dis);
    end
    // Reset arriving in the middle of the vector fetch
    ext_pull_low = 1'b1;
    wait_force(1'b1);
    ext_pull_low = 1'b0;
    wait_force(1'b0);
    // Pull the pin on the first fetch cycle so the sync lands on the third fetch cycle, before run
    step(1);
    check({vector_fetch, fetch_index}, 3'h4);
    ext_pull_low = 1'b1;
    step(3);
    check({force_active, vector_fetch, cpu_run}, 3'h4);
    ext_pull_low = 1'b0;
    release_and_fetch(16'hfffe);
    print_verdict();
  end

  // Whole run is well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    print_verdict();
  end
endmodule : rif_top_test
